// file: logic/srb_pkg.sv
// constants, types and register map for the receive back end block
// assumes one clock (aclk, 10 MHz) and an AXI4-Lite register master
package srb_pkg;

  // ****************************************************
  // register map (byte addresses)
  // ****************************************************
  localparam logic [3:0] REG_CTRL_ADDR   = 4'h0; // read/write control
  localparam logic [3:0] REG_STATUS_ADDR = 4'h4; // read only state
  localparam logic [3:0] REG_FLAGS_ADDR  = 4'h8; // sticky, write 1 clear

  // control field positions
  localparam int CTRL_MODE_LSB  = 0;  // 2-bit functional mode
  localparam int CTRL_LPBK_LSB  = 2;  // 2-bit software loopback select
  localparam int CTRL_PREEMPH   = 4;  // transmit pre-emphasis enable
  localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;

  // status field positions
  localparam int STAT_LPBK_LSB  = 0;  // 3-bit active loopback
  localparam int STAT_LEVEL_LSB = 4;  // 4-bit fifo fill level
  localparam int STAT_DEPTH_LSB = 8;  // 4-bit active fifo depth
  localparam int FLAG_OVF       = 0;  // fifo overflow seen

  // fifo depths per mode
  localparam int FIFO_DEPTH_PIPE  = 8;
  localparam int FIFO_DEPTH_OTHER = 4;

  // link power state P0 encoding
  localparam logic [1:0] PSTATE_P0 = 2'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // functional modes in the order of the control field
  typedef enum logic [1:0] {
    MODE_BASIC, MODE_GIGE, MODE_SRIO, MODE_PIPE
  } srb_mode_t;

  // software loopback select values
  localparam logic [1:0] SW_LPBK_NONE  = 2'h0;
  localparam logic [1:0] SW_LPBK_REVSER = 2'h1;
  localparam logic [1:0] SW_LPBK_PRECDR = 2'h2;

  // active loopback path
  typedef enum logic [2:0] {
    LB_NONE, LB_SERIAL, LB_REV_SERIAL, LB_REV_PRECDR, LB_REV_PARALLEL
  } srb_lpbk_t;

  // one decoded byte with its flags
  typedef struct packed {
    logic [7:0] data;    // decoded byte
    logic       ctrl;    // control character
    logic       err;     // code error
    logic       disperr; // disparity error
  } srb_byte_t;

  // fabric word: lower half earlier byte
  typedef struct packed {
    srb_byte_t hi;       // later byte
    srb_byte_t lo;       // earlier byte
  } srb_word_t;

  // clear and shutdown fan-out to neighbouring blocks
  typedef struct packed {
    logic rx_dig;        // aligner, matcher, decoder, rx xaui, checkers
    logic rx_ana;        // deserializer, rx pll/recovery, rx analog
    logic tx_dig;        // tx fifo/serializer, encoder, tx xaui, gens
    logic tx_ana;        // tx serializer, analog, tx pll
  } srb_clear_t;

endpackage

// file: logic/srb_rx_backend.sv
// receive back end: byte pairing, phase fifo, loopback and reset map
// assumes decoder, matcher and serial bits arrive on aclk, except the
// receive serial pin which is synchronised here
`timescale 1ns/1ps
`default_nettype none
module srb_rx_backend import srb_pkg::*; #(
  parameter int DEPTH_MAX = FIFO_DEPTH_PIPE   // storage words
) (
  input  wire logic        aclk,             // 10 MHz clock
  input  wire logic        aresetn,          // sync reset, low active
  // axi4-lite slave
  input  wire logic [3:0]  s_awaddr,         // write address
  input  wire logic        s_awvalid,        // write address valid
  output logic             s_awready,        // write address ready
  input  wire logic [31:0] s_wdata,          // write data
  input  wire logic [3:0]  s_wstrb,          // write strobes
  input  wire logic        s_wvalid,         // write data valid
  output logic             s_wready,         // write data ready
  output logic [1:0]       s_bresp,          // write response
  output logic             s_bvalid,         // write response valid
  input  wire logic        s_bready,         // write response ready
  input  wire logic [3:0]  s_araddr,         // read address
  input  wire logic        s_arvalid,        // read address valid
  output logic             s_arready,        // read address ready
  output logic [31:0]      s_rdata,          // read data
  output logic [1:0]       s_rresp,          // read response
  output logic             s_rvalid,         // read data valid
  input  wire logic        s_rready,         // read data ready
  // decoder byte stream
  input  wire logic        dec_valid,        // one byte this cycle
  input  wire srb_byte_t   dec_byte,         // byte and flags
  // fabric side
  output srb_word_t        fab_word,         // paired word
  output logic             fab_valid,        // word valid
  input  wire logic        fab_ready,        // fabric takes word
  // loopback controls and serial points
  input  wire logic        serial_lpbk_en,   // serial loopback request
  input  wire logic        det_lpbk,         // detect/loopback request
  input  wire logic [1:0]  pipe_pstate,      // link power state
  input  wire logic        ser_bit,          // serializer output bit
  input  wire logic        rx_serial_in,     // receive pin, async
  input  wire logic        cdr_bit,          // retimed recovery bit
  input  wire logic [9:0]  rm_data,          // rate matcher output
  input  wire logic [9:0]  tx_par,           // fabric tx parallel word
  output logic             recovery_in,      // clock_recovery_unit in
  output logic             tx_serial_out,    // transmit serial out
  output logic [9:0]       ser_par_in,       // serializer input
  output logic             preemph_en,       // pre-emphasis active
  // resets and powerdown
  input  wire logic        tx_digital_rst,   // per channel
  input  wire logic        rx_analog_rst,    // per channel
  input  wire logic        rx_digital_rst,   // per channel
  input  wire logic        blk_powerdown,    // block power down, high
  input  wire logic        blk_enable,       // block enable, low = off
  output srb_clear_t       clear_out         // clears to other blocks
);

  // ****************************************************
  // clear map
  // ****************************************************
  logic pwrdn;        // either block-wide shutdown
  logic rx_dig_clr;   // clears pairing and fifo here
  assign pwrdn      = blk_powerdown | ~blk_enable;
  assign rx_dig_clr = ~aresetn | rx_digital_rst | pwrdn;

  // registered fan-out; deskew fifo is not on this list on purpose
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clear_out <= '{default: 1'b1};
    end else begin
      clear_out.rx_dig <= rx_digital_rst | pwrdn;
      clear_out.rx_ana <= rx_analog_rst | pwrdn;
      clear_out.tx_dig <= tx_digital_rst | pwrdn;
      clear_out.tx_ana <= pwrdn;
    end
  end

  // ****************************************************
  // control register and mode
  // ****************************************************
  logic [31:0] ctrl_reg;   // software control
  logic        ovf_reg;    // sticky overflow
  srb_mode_t   mode;       // functional mode
  logic [1:0]  sw_lpbk;    // software loopback select
  logic [3:0]  depth;      // active fifo depth
  assign mode    = srb_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  assign sw_lpbk = ctrl_reg[CTRL_LPBK_LSB +: 2];
  // a smaller depth in non-pipe modes keeps latency low
  assign depth = (mode == MODE_PIPE) ? 4'(FIFO_DEPTH_PIPE)
                                     : 4'(FIFO_DEPTH_OTHER);

  // ****************************************************
  // byte pairing
  // ****************************************************
  logic      half_reg;     // first byte of a pair held
  srb_byte_t first_reg;    // earlier byte
  logic      push;         // word into fifo
  srb_word_t push_word;    // word to store

  // in gige each byte goes on alone with zero upper half
  always_comb begin
    if (mode == MODE_GIGE) begin
      push      = dec_valid;
      push_word = '{hi: '0, lo: dec_byte};
    end else begin
      push      = dec_valid & half_reg;
      push_word = '{hi: dec_byte, lo: first_reg};
    end
  end

  // pairing phase is not aligned to any symbol; fabric sorts swaps
  always_ff @(posedge aclk) begin
    if (rx_dig_clr || mode == MODE_GIGE) begin
      half_reg  <= 1'b0;
      first_reg <= '0;
    end else if (dec_valid) begin
      half_reg <= ~half_reg;
      if (!half_reg) begin
        first_reg <= dec_byte;
      end
    end
  end

  // ****************************************************
  // phase compensation fifo
  // ****************************************************
  srb_word_t mem [DEPTH_MAX];  // storage
  logic [2:0] wptr_reg;        // write pointer
  logic [2:0] rptr_reg;        // read pointer
  logic [3:0] level_reg;       // words held
  logic       rate_reg;        // half-rate enable toggle
  logic       slot;            // fabric beat this cycle
  logic       pop;             // fifo to output stage
  logic       wr;              // accepted push

  // fabric side runs at half rate unless bytes pass singly
  assign slot = (mode == MODE_GIGE) | rate_reg;
  assign pop  = slot & (level_reg != 4'h0) & (~fab_valid | fab_ready);
  assign wr   = push & (level_reg < depth);

  // half-rate divider
  always_ff @(posedge aclk) begin
    if (rx_dig_clr) begin
      rate_reg <= 1'b0;
    end else begin
      rate_reg <= ~rate_reg;
    end
  end

  // storage write; pointers wrap at the active depth
  always_ff @(posedge aclk) begin
    if (wr) begin
      mem[wptr_reg] <= push_word;
    end
  end

  // pointer and level update
  always_ff @(posedge aclk) begin
    if (rx_dig_clr) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      level_reg <= '0;
    end else begin
      if (wr) begin
        wptr_reg <= (4'(wptr_reg) == depth - 4'h1) ? 3'h0 : wptr_reg + 3'h1;
      end
      if (pop) begin
        rptr_reg <= (4'(rptr_reg) == depth - 4'h1) ? 3'h0 : rptr_reg + 3'h1;
      end
      level_reg <= level_reg + 4'(wr) - 4'(pop);
    end
  end

  // output stage, data from flops
  always_ff @(posedge aclk) begin
    if (rx_dig_clr) begin
      fab_valid <= 1'b0;
      fab_word  <= '0;
    end else if (pop) begin
      fab_valid <= 1'b1;
      fab_word  <= mem[rptr_reg];
    end else if (fab_ready) begin
      fab_valid <= 1'b0;
    end
  end

  // ****************************************************
  // loopback selection
  // ****************************************************
  logic      rx_meta_reg;  // pin sync stage 1
  logic      rx_sync_reg;  // pin sync stage 2
  srb_lpbk_t lpbk;         // active loopback

  // receive pin synchroniser
  always_ff @(posedge aclk) begin
    rx_meta_reg <= rx_serial_in;
    rx_sync_reg <= rx_meta_reg;
  end

  // pins win over software; changes need no reset and the fabric
  // must ride out garbage while recovery relocks
  always_comb begin
    if (serial_lpbk_en && (mode == MODE_GIGE || mode == MODE_SRIO)) begin
      lpbk = LB_SERIAL;
    end else if (det_lpbk && mode == MODE_PIPE &&
                 pipe_pstate == PSTATE_P0) begin
      lpbk = LB_REV_PARALLEL;
    end else if (sw_lpbk == SW_LPBK_REVSER) begin
      lpbk = LB_REV_SERIAL;
    end else if (sw_lpbk == SW_LPBK_PRECDR) begin
      lpbk = LB_REV_PRECDR;
    end else begin
      lpbk = LB_NONE;
    end
  end

  // registered data path muxes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      recovery_in   <= 1'b0;
      tx_serial_out <= 1'b0;
      ser_par_in    <= '0;
      preemph_en    <= 1'b0;
    end else begin
      recovery_in <= (lpbk == LB_SERIAL) ? ser_bit : rx_sync_reg;
      unique case (lpbk)
        LB_REV_SERIAL: tx_serial_out <= cdr_bit;
        LB_REV_PRECDR: tx_serial_out <= rx_sync_reg;
        default:       tx_serial_out <= ser_bit;
      endcase
      ser_par_in <= (lpbk == LB_REV_PARALLEL) ? rm_data : tx_par;
      preemph_en <= ctrl_reg[CTRL_PREEMPH] &
                    (lpbk != LB_REV_PRECDR);
    end
  end

  // ****************************************************
  // axi4-lite slave
  // ****************************************************
  logic       aw_held_reg;  // write address latched
  logic       w_held_reg;   // write data latched
  logic [3:0] awaddr_reg;   // latched address
  logic [31:0] wdata_reg;   // latched data
  logic [3:0] wstrb_reg;    // latched strobes
  logic       do_write;     // both halves present
  logic       w1c_ovf;      // overflow clear request
  logic [31:0] rd_val;      // read mux
  logic       rd_hit;       // mapped read

  assign s_awready = ~aw_held_reg & ~s_bvalid;
  assign s_wready  = ~w_held_reg & ~s_bvalid;
  assign s_arready = ~s_rvalid;
  assign do_write  = aw_held_reg & w_held_reg;
  assign w1c_ovf   = do_write & (awaddr_reg == REG_FLAGS_ADDR) &
                     wstrb_reg[0] & wdata_reg[FLAG_OVF];

  // address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_wdata;
        wstrb_reg  <= s_wstrb;
      end
    end
  end

  // control register with byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET_VAL;
    end else if (do_write && awaddr_reg == REG_CTRL_ADDR) begin
      for (int i = 0; i < 4; i++) begin
        if (wstrb_reg[i]) begin
          ctrl_reg[i*8 +: 8] <= wdata_reg[i*8 +: 8];
        end
      end
    end
  end

  // overflow flag: a new overflow beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_reg <= 1'b0;
    end else if (push && !wr) begin
      ovf_reg <= 1'b1;
    end else if (w1c_ovf) begin
      ovf_reg <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_bvalid <= 1'b1;
      s_bresp  <= (awaddr_reg == REG_STATUS_ADDR ||
                   awaddr_reg == REG_CTRL_ADDR ||
                   awaddr_reg == REG_FLAGS_ADDR) ? RESP_OKAY : RESP_DECERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // read mux; unmapped reads give zero and decode error
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    unique case (s_araddr)
      REG_CTRL_ADDR: rd_val = ctrl_reg;
      REG_STATUS_ADDR: begin
        rd_val[STAT_LPBK_LSB +: 3]  = lpbk;
        rd_val[STAT_LEVEL_LSB +: 4] = level_reg;
        rd_val[STAT_DEPTH_LSB +: 4] = depth;
      end
      REG_FLAGS_ADDR: rd_val[FLAG_OVF] = ovf_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= '0;
      s_rresp  <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_val;
      s_rresp  <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: tb/srb_rx_backend_checker.sv
// checker: reset fan-out and fabric hand-off of the receive back end
// assumes it is bound onto srb_rx_backend; one clock domain
`timescale 1ns/1ps
`default_nettype none
module srb_rx_backend_checker import srb_pkg::*; (
  input wire logic       aclk,           // clock
  input wire logic       aresetn,        // sync reset, low
  input wire srb_word_t  fab_word,       // fabric word
  input wire logic       fab_valid,      // word valid
  input wire logic       fab_ready,      // fabric takes word
  input wire logic       tx_digital_rst, // tx digital reset
  input wire logic       rx_analog_rst,  // rx analog reset
  input wire logic       rx_digital_rst, // rx digital reset
  input wire logic       blk_powerdown,  // block power down
  input wire logic       blk_enable,     // low shuts block
  input wire srb_clear_t clear_out       // clear fan-out
);
  // ****************************************************
  // properties
  // ****************************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // reset requests packed like clear_out; either power-down folds to bit 0
  wire logic [3:0] req = {rx_digital_rst, rx_analog_rst, tx_digital_rst,
                          blk_powerdown || !blk_enable};

  AST_REL_CLEAR: assert property ($rose(aresetn) |->
    clear_out == 4'hF && !fab_valid) else $error("state not clear at release");
  AST_RXD_ONLY: assert property ($past(aresetn) && req == 4'h8 |=>
    clear_out == 4'h8) else $error("rx digital reset scope wrong");
  AST_RXA_ONLY: assert property ($past(aresetn) && req == 4'h4 |=>
    clear_out == 4'h4) else $error("rx analog reset scope wrong");
  AST_TXD_ONLY: assert property ($past(aresetn) && req == 4'h2 |=>
    clear_out == 4'h2) else $error("tx digital reset scope wrong");
  AST_PWR_ALL: assert property (req[0] |-> ##1 clear_out == 4'hF)
    else $error("power down did not clear all");
  AST_FAB_HOLD: assert property (fab_valid && !fab_ready && req == 4'h0
    |=> fab_valid && $stable(fab_word)) else $error("word dropped unread");
  AST_FAB_RXD: assert property (rx_digital_rst |=> !fab_valid)
    else $error("fabric word kept over rx reset");
  AST_FAB_PWR: assert property (req[0] [*2] |=> !fab_valid)
    else $error("fabric word kept over power down");
endmodule

bind srb_rx_backend srb_rx_backend_checker u_chk (
  .aclk, .aresetn, .fab_word, .fab_valid, .fab_ready, .tx_digital_rst,
  .rx_analog_rst, .rx_digital_rst, .blk_powerdown, .blk_enable, .clear_out
);
`default_nettype wire

// file: tb/srb_fabric_model.sv
// fabric-side partner: paces fab_ready and records every word taken
// assumes the bench sets stall and slow off the clock edge
`timescale 1ns/1ps
`default_nettype none
module srb_fabric_model import srb_pkg::*; (
  input  wire logic      aclk,      // clock
  input  wire logic      aresetn,   // sync reset, low
  input  wire srb_word_t fab_word,  // word offered
  input  wire logic      fab_valid, // word valid
  input  wire logic      stall,     // refuse all words
  input  wire logic      slow,      // accept every other cycle
  output var logic       fab_ready  // word taken
);
  srb_word_t got[$]; // words taken, oldest first

  // ready pacing: prompt, half rate or stalled
  always @(posedge aclk) begin
    if (!aresetn) begin
      fab_ready <= 1'b0;
    end else begin
      fab_ready <= !stall && (!slow || !fab_ready);
    end
  end

  // words kept exactly as delivered; byte swap repair is left to users
  always @(posedge aclk) begin
    if (aresetn && fab_valid && fab_ready) begin
      got.push_back(fab_word);
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_srb_rx_backend.sv
// testbench for srb_rx_backend: register bus, stream, loopback, resets
// assumes the fabric model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module tb_srb_rx_backend import srb_pkg::*;;
  logic        aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready;
  logic        s_bready, s_bvalid, s_arvalid, s_arready, s_rready, s_rvalid;
  logic [3:0]  s_awaddr, s_araddr, s_wstrb;
  logic [31:0] s_wdata, s_rdata, d;
  logic [1:0]  s_bresp, s_rresp, pipe_pstate, r;
  logic        dec_valid, fab_valid, fab_ready, serial_lpbk_en, det_lpbk;
  logic        recovery_in, tx_serial_out, preemph_en, stall, slow;
  logic        tx_digital_rst, rx_analog_rst, rx_digital_rst, blk_powerdown;
  logic        blk_enable;
  logic [9:0]  ser_par_in, pat, pat_q; // pat feeds the serial points
  srb_byte_t   dec_byte;
  srb_word_t   fab_word;
  srb_clear_t  clear_out;
  int          failures, n_checks, nw;
  // ordinary cases: mode, two bytes, words the fabric should see
  typedef struct packed {
    srb_mode_t  m;
    srb_byte_t  a, b;
    srb_word_t  e0, e1;
    logic [1:0] n;
  } srb_row_t;
  srb_row_t rows [4] = '{
    '{MODE_BASIC, 11'h1A2, 11'h7F5, {11'h7F5, 11'h1A2}, 22'h0, 2'h1},
    '{MODE_SRIO, 11'h004, 11'h7FB, {11'h7FB, 11'h004}, 22'h0, 2'h1},
    '{MODE_PIPE, 11'h5A6, 11'h0A3, {11'h0A3, 11'h5A6}, 22'h0, 2'h1},
    '{MODE_GIGE, 11'h3FC, 11'h401, {11'h000, 11'h3FC}, {11'h000, 11'h401},
      2'h2}};

  srb_rx_backend DUT (
    .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
    .dec_valid, .dec_byte, .fab_word, .fab_valid, .fab_ready,
    .serial_lpbk_en, .det_lpbk, .pipe_pstate, .ser_bit(pat[0]),
    .rx_serial_in(pat[2]), .cdr_bit(pat[1]), .rm_data(pat), .tx_par(~pat),
    .recovery_in, .tx_serial_out, .ser_par_in, .preemph_en, .tx_digital_rst,
    .rx_analog_rst, .rx_digital_rst, .blk_powerdown, .blk_enable, .clear_out);
  srb_fabric_model fm (.aclk, .aresetn, .fab_word, .fab_valid, .stall, .slow,
    .fab_ready);

  // ****************************************************
  // clock, serial pattern, tasks
  // ****************************************************
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // pat_q holds what the design sampled at the last edge
  always @(posedge aclk) begin
    pat <= pat + 10'h001;
    pat_q <= pat;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    logic aw, w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_awready) begin
        aw = 1'b0;
        s_awvalid <= 1'b0;
      end
      if (w && s_wready) begin
        w = 1'b0;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_bvalid);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask
  // read: result left in d and r
  task automatic axr(input logic [3:0] a);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_rvalid);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask
  // one byte per call, so calls in a row are back to back
  task automatic sb(input srb_byte_t b);
    @(posedge aclk);
    dec_valid <= 1'b1;
    dec_byte <= b;
  endtask
  task automatic idle();
    @(posedge aclk);
    dec_valid <= 1'b0;
  endtask
  task automatic expw(input srb_word_t e);
    while (fm.got.size() <= nw) @(posedge aclk);
    chk(32'(fm.got[nw]), 32'(e));
    nw++;
  endtask
  task automatic lpst(input logic [2:0] v);
    repeat (3) @(posedge aclk);
    axr(REG_STATUS_ADDR);
    chk(32'(d[2:0]), 32'(v));
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, dec_byte, pipe_pstate, pat, pat_q} = '0;
    {dec_valid, serial_lpbk_en, det_lpbk, stall, slow} = '0;
    {tx_digital_rst, rx_analog_rst, rx_digital_rst, blk_powerdown} = '0;
    s_wstrb = 4'hF;
    blk_enable = 1'b1;
    failures = 0;
    n_checks = 0;
    nw = 0;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(32'(clear_out), 32'hF);
    @(posedge aclk);
    aresetn <= 1'b1;
    axr(REG_CTRL_ADDR);
    chk(d, CTRL_RESET_VAL);
    axr(REG_STATUS_ADDR);
    chk(32'(d[11:8]), 32'(FIFO_DEPTH_OTHER));
    axr(4'hC);
    chk({d[29:0], r}, {30'h0, RESP_DECERR});
    // unmapped write must be refused with a decode error
    axw(4'hC, 32'h0);
    chk(32'(r), 32'(RESP_DECERR));
    foreach (rows[i]) begin
      axw(REG_CTRL_ADDR, 32'(rows[i].m));
      slow <= i[0];
      sb(rows[i].a);
      sb(rows[i].b);
      idle();
      expw(rows[i].e0);
      if (rows[i].n == 2'h2) expw(rows[i].e1);
    end
    // nine words (eight stored plus the output stage) fit only the
    // deeper fifo; order kept on drain
    axw(REG_CTRL_ADDR, 32'(MODE_PIPE));
    axr(REG_STATUS_ADDR);
    chk(32'(d[11:8]), 32'(FIFO_DEPTH_PIPE));
    stall <= 1'b1;
    for (int k = 0; k < 18; k++) sb({8'h40 + 8'(k), 3'h0});
    idle();
    repeat (10) @(posedge aclk);
    axr(REG_FLAGS_ADDR);
    chk(d, 32'h0);
    stall <= 1'b0;
    for (int k = 0; k < 18; k += 2) begin
      expw({8'h41 + 8'(k), 3'h0, 8'h40 + 8'(k), 3'h0});
    end
    // ten words against the shallow fifo must overflow
    axw(REG_CTRL_ADDR, 32'(MODE_BASIC));
    stall <= 1'b1;
    for (int k = 0; k < 20; k++) sb({8'h80 + 8'(k), 3'h1});
    idle();
    repeat (10) @(posedge aclk);
    axr(REG_FLAGS_ADDR);
    chk(d, 32'h1);
    axw(REG_FLAGS_ADDR, 32'h1);
    chk(32'(r), 32'(RESP_OKAY));
    axr(REG_FLAGS_ADDR);
    chk(d, 32'h0);
    stall <= 1'b0;
    // the five words held are the earliest; the rest were dropped
    for (int k = 0; k < 10; k += 2) begin
      expw({8'h81 + 8'(k), 3'h1, 8'h80 + 8'(k), 3'h1});
    end
    repeat (40) @(posedge aclk);
    chk(32'(fm.got.size()), 32'(nw));
    nw = fm.got.size();
    // a lone byte is lost to rx digital reset
    sb(11'h555);
    idle();
    rx_digital_rst <= 1'b1;
    @(posedge aclk);
    rx_digital_rst <= 1'b0;
    sb(11'h2AA);
    sb(11'h0F0);
    idle();
    expw({11'h0F0, 11'h2AA});
    // loopback paths
    axw(REG_CTRL_ADDR, 32'(MODE_SRIO));
    serial_lpbk_en <= 1'b1;
    lpst(3'h1);
    @(negedge aclk);
    chk({recovery_in, tx_serial_out}, {2{pat_q[0]}});
    sb(11'h123);
    sb(11'h456);
    idle();
    expw({11'h456, 11'h123});
    serial_lpbk_en <= 1'b0;
    lpst(3'h0);
    axw(REG_CTRL_ADDR, 32'(MODE_GIGE));
    serial_lpbk_en <= 1'b1;
    lpst(3'h1);
    axw(REG_CTRL_ADDR, 32'h10);
    lpst(3'h0);
    serial_lpbk_en <= 1'b0;
    chk(32'(preemph_en), 32'h1);
    axw(REG_CTRL_ADDR, 32'h14);
    lpst(3'h2);
    @(negedge aclk);
    chk(32'(tx_serial_out), 32'(pat_q[1]));
    axw(REG_CTRL_ADDR, 32'h18);
    lpst(3'h3);
    chk(32'(preemph_en), 32'h0);
    // pin passes two sync stages and the output flop: three edges old
    @(negedge aclk);
    chk(32'(pat_q - 10'h2) >> 2 & 32'h1, 32'(tx_serial_out));
    axw(REG_CTRL_ADDR, 32'(MODE_PIPE));
    det_lpbk <= 1'b1;
    lpst(3'h4);
    @(negedge aclk);
    chk(32'(ser_par_in), 32'(pat_q));
    sb(11'h6DB);
    sb(11'h249);
    idle();
    expw({11'h249, 11'h6DB});
    pipe_pstate <= 2'h2;
    lpst(3'h0);
    @(negedge aclk);
    chk(32'(ser_par_in ^ pat_q), 32'h3FF);
    // each reset input alone, then both power-downs, with no traffic
    // running so calibration is never cut under live data
    for (int k = 0; k < 5; k++) begin
      @(posedge aclk);
      {rx_digital_rst, rx_analog_rst, tx_digital_rst, blk_powerdown} <=
        4'(4'h8 >> k);
      blk_enable <= (k != 4);
      repeat (3) @(posedge aclk);
      chk(32'(clear_out), (k > 2) ? 32'hF : 32'(4'h8 >> k));
      {rx_digital_rst, rx_analog_rst, tx_digital_rst, blk_powerdown} <= 4'h0;
      blk_enable <= 1'b1;
    end
    end_sim();
  end

  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
